// ---- hw/wdt_pkg.sv ----
// package: watchdog register map, field layout, reset values and timing constants
package wdt_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] CONTROL_OFFSET = 8'hC4;
  localparam logic [7:0] AUTOLOAD_OFFSET = 8'hC8;
  localparam logic [7:0] FEED_FIRST_OFFSET = 8'hCC;
  localparam logic [7:0] FEED_SECOND_OFFSET = 8'hD0;
  localparam logic [7:0] POWER_CONTROL_OFFSET = 8'hD4;
  localparam logic [7:0] STATUS_OFFSET = 8'hD8;
  // control field positions
  localparam int MODE_BIT = 0;
  localparam int RUN_BIT = 1;
  localparam int PD_DISABLE_BIT = 2;
  localparam int OSC_FAIL_BIT = 3;
  localparam int LOW_VOLT_BIT = 4;
  localparam int TAP_LSB = 5;
  // power control: time-out flag position
  localparam int TIMEOUT_FLAG_BIT = 4;
  // reset values and feed keys
  localparam logic [7:0] CONTROL_RESET = 8'hFB;
  localparam logic [7:0] AUTOLOAD_RESET = 8'h00;
  localparam logic [7:0] FEED_FIRST_KEY = 8'hA5;
  localparam logic [7:0] FEED_SECOND_KEY = 8'h5A;
  // prescaler geometry and mask defaults
  localparam int PRESCALE_STAGES = 13;
  localparam int FIRST_TAP_STAGE = 6;
  localparam logic [7:0] MASK_CONTROL_DEFAULT = 8'hFB;
  localparam logic [7:0] MASK_AUTOLOAD_DEFAULT = 8'h00;

  typedef struct packed {
    logic [2:0] tap;
    logic low_volt_reset_en;
    logic osc_fail_reset_en;
    logic power_down_disable;
    logic run;
    logic mode_watchdog;
  } control_t;
endpackage

// ---- hw/watchdog_timer_subsystem.sv ----
// watchdog timer subsystem with apb register access
// What this block does
// - settings from registers, or mask when pin high
// - mask timer mode still uses software load/taps
// - run bit: timer mode only, no feed needed
// - reset: watchdog mode, running, load zero, autoload
// - feeds accepted in timer mode too
// - underflow at reset still sets flag
// - watchdog underflow: autoload, flag, system reset
// - flag never cleared by hardware
// - timer underflow: autoload and flag only
// - mask mode bit read-only, run per mode
// - divide by two, 13 stages, taps 6-13
// - 8-bit down counter on tap overflow
// - decrement at zero underflows; autoload clears prescaler
// - time-out scales with tap and load plus one
// - mask part: control bits other than run read-only mask values; taps from software in timer mode
// - shadow copied to active on valid feed
// - reset gives watchdog mode, longest tap
// - no interrupt request ever
// - control other than run bit effective only through feed
// - taps bits 7-5, run bit 1, mode bit 0
// - bit 4 low-volt, bit 3 osc-fail, bit 2 power-down
// - feed is A5 then 5A; wrong second underflows
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_subsystem #(
  parameter logic [7:0] MASK_CONTROL = wdt_pkg::MASK_CONTROL_DEFAULT,
  parameter logic [7:0] MASK_AUTOLOAD = wdt_pkg::MASK_AUTOLOAD_DEFAULT,
  parameter bit MASK_ROM_PART = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins and system
  input wire logic external_access_pin,
  input wire logic osc_tick,
  output logic system_reset_request,
  output logic low_voltage_reset_enable,
  output logic osc_fail_reset_enable,
  output logic power_down_disable
);
  localparam int PRESCALE_W = wdt_pkg::PRESCALE_STAGES;
  wdt_pkg::control_t user_control;
  wdt_pkg::control_t active_control;
  wdt_pkg::control_t mask_control;
  wdt_pkg::control_t eff_control;
  logic [7:0] autoload_value_register;
  logic [7:0] eff_autoload;
  logic [7:0] main_count;
  logic [PRESCALE_W-1:0] prescaler;
  logic [PRESCALE_W-1:0] next_prescaler;
  logic divide_phase;
  logic feed_armed;
  logic timeout_flag;
  logic use_mask;
  logic wr;
  logic feed_ok;
  logic feed_bad;
  logic tap_overflow;
  logic counting;
  logic underflow;
  logic [7:0] ctrl_read;

  assign mask_control = wdt_pkg::control_t'(MASK_CONTROL);
  assign use_mask = MASK_ROM_PART && external_access_pin;
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // effective settings: mask part keeps software taps/load in timer mode
  always_comb begin
    eff_control = active_control;
    eff_autoload = autoload_value_register;
    if (use_mask) begin
      eff_control = mask_control;
      eff_control.run = active_control.run;
      if (!mask_control.mode_watchdog) begin
        eff_control.tap = active_control.tap;
      end else begin
        eff_autoload = MASK_AUTOLOAD;
      end
    end
  end

  assign low_voltage_reset_enable = eff_control.low_volt_reset_en;
  assign osc_fail_reset_enable = eff_control.osc_fail_reset_en;
  assign power_down_disable = eff_control.power_down_disable;

  assign feed_ok = wr && feed_armed && paddr == wdt_pkg::FEED_SECOND_OFFSET
                   && pwdata[7:0] == wdt_pkg::FEED_SECOND_KEY;
  // any other access after a good first write breaks the pair
  assign feed_bad = feed_armed && psel && penable && !feed_ok;

  // run bit only gates counting in timer mode
  assign counting = !eff_control.mode_watchdog ? eff_control.run : 1'b1;

  // divide by two then 13-stage counter; tap overflow is the carry out of that stage
  always_comb begin
    next_prescaler = prescaler + PRESCALE_W'(1);
  end
  assign tap_overflow = osc_tick && divide_phase && counting &&
    (&prescaler[wdt_pkg::FIRST_TAP_STAGE - 1 + 32'(eff_control.tap) -: 1] ) &&
    (&(prescaler | ~(PRESCALE_W'((32'd1 << (wdt_pkg::FIRST_TAP_STAGE
      + 32'(eff_control.tap))) - 32'd1))));
  assign underflow = (tap_overflow && main_count == 8'h00) || feed_bad;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divide_phase <= 1'b0;
      prescaler <= '0;
    end else if (underflow || feed_ok) begin
      divide_phase <= 1'b0;
      prescaler <= '0;
    end else if (osc_tick && counting) begin
      divide_phase <= ~divide_phase;
      if (divide_phase) begin
        prescaler <= next_prescaler;
      end
    end
  end

  // main counter; reset performs an autoload of zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_count <= wdt_pkg::AUTOLOAD_RESET;
    end else if (underflow || feed_ok) begin
      main_count <= eff_autoload;
    end else if (tap_overflow) begin
      main_count <= main_count - 8'h01;
    end
  end

  // system reset pulse only in watchdog mode; never an interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset_request <= 1'b0;
    end else begin
      system_reset_request <= underflow && eff_control.mode_watchdog;
    end
  end

  // flag survives reset: held in a flop with no reset, cleared by software only
  always_ff @(posedge pclk) begin
    if (underflow) begin
      timeout_flag <= 1'b1;
    end else if (wr && paddr == wdt_pkg::POWER_CONTROL_OFFSET
                 && !pwdata[wdt_pkg::TIMEOUT_FLAG_BIT]) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feed_armed <= 1'b0;
    end else if (psel && penable) begin
      feed_armed <= wr && paddr == wdt_pkg::FEED_FIRST_OFFSET
                    && pwdata[7:0] == wdt_pkg::FEED_FIRST_KEY;
    end
  end

  // user copy of control and autoload value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_control <= wdt_pkg::control_t'(wdt_pkg::CONTROL_RESET);
      autoload_value_register <= wdt_pkg::AUTOLOAD_RESET;
    end else if (wr && paddr == wdt_pkg::CONTROL_OFFSET) begin
      user_control <= wdt_pkg::control_t'(pwdata[7:0]);
    end else if (wr && paddr == wdt_pkg::AUTOLOAD_OFFSET) begin
      autoload_value_register <= pwdata[7:0];
    end
  end

  // active copy: all but run move only on a feed; run changes at once unless the mask part is in watchdog mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_control <= wdt_pkg::control_t'(wdt_pkg::CONTROL_RESET);
    end else begin
      if (feed_ok) begin
        active_control <= user_control;
      end
      if (wr && paddr == wdt_pkg::CONTROL_OFFSET
          && !(use_mask && mask_control.mode_watchdog)) begin
        active_control.run <= pwdata[wdt_pkg::RUN_BIT];
      end
    end
  end

  always_comb begin
    ctrl_read = use_mask ? eff_control : user_control;
    ctrl_read[wdt_pkg::RUN_BIT] = eff_control.run;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        wdt_pkg::CONTROL_OFFSET: prdata <= {24'h000000, ctrl_read};
        wdt_pkg::AUTOLOAD_OFFSET: prdata <= {24'h000000, autoload_value_register};
        wdt_pkg::POWER_CONTROL_OFFSET: prdata <= 32'(timeout_flag) << wdt_pkg::TIMEOUT_FLAG_BIT;
        wdt_pkg::STATUS_OFFSET: prdata <= {24'h000000, main_count};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verif/wdt_chk.sv ----
// checker: port-level watchdog properties
`timescale 1ns/1ps
`default_nettype none
module wdt_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // system
  input wire logic system_reset_request,
  input wire logic low_voltage_reset_enable,
  input wire logic osc_fail_reset_enable,
  input wire logic power_down_disable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, rd, seen;
  logic [2:0] en;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign en = {low_voltage_reset_enable, osc_fail_reset_enable, power_down_disable};
  // a seen flag may only drop through a software write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) seen <= 1'b0;
    else if (acc && paddr == 8'hD4) seen <= rd && prdata[4];
  property p_pulse; system_reset_request |=> !system_reset_request; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_rst; $rose(presetn) |-> en == 3'b110; endproperty
  a_rst: assert property (p_rst) else $error("enables wrong after reset");
  property p_shadow;
    $changed(en) |-> $past(acc && pwrite && paddr == 8'hD0 && pwdata[7:0] == 8'h5A);
  endproperty
  a_shadow: assert property (p_shadow) else $error("settings moved without feed");
  property p_ctrl; acc && pwrite && paddr == 8'hC4 |=> $stable(en); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write acted at once");
  property p_load; rd && paddr == 8'hC8 |-> prdata[31:8] == 24'h0; endproperty
  a_load: assert property (p_load) else $error("autoload wider than 8 bits");
  property p_count; rd && paddr == 8'hD8 |-> prdata[31:8] == 24'h0; endproperty
  a_count: assert property (p_count) else $error("count wider than 8 bits");
  property p_flag; rd && paddr == 8'hD4 && seen |-> prdata[4]; endproperty
  a_flag: assert property (p_flag) else $error("flag cleared by hardware");
  property p_apb; acc |-> pready && !pslverr; endproperty
  a_apb: assert property (p_apb) else $error("bus answer wrong");
  c_feed: cover property (acc && pwrite && paddr == 8'hD0);
  c_pulse: cover property (system_reset_request);
  c_ctrl: cover property (acc && pwrite && paddr == 8'hC4);
endmodule
bind watchdog_timer_subsystem wdt_chk i_wdt_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .system_reset_request(system_reset_request),
  .low_voltage_reset_enable(low_voltage_reset_enable),
  .osc_fail_reset_enable(osc_fail_reset_enable), .power_down_disable(power_down_disable));
`default_nettype wire

// ---- verif/tb.sv ----
// testbench: registers, feeds, time-out and reset of the watchdog
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, ext, tick, pready, pslverr, srr, lv, of, pd;
  logic [7:0] paddr, w, rnd;
  logic [31:0] pwdata, prdata, r, s;
  int err_count = 0, n_tests = 0, cyc = 0, pulses = 0, t;
  watchdog_timer_subsystem i_watchdog_timer_subsystem (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_access_pin(ext),
    .osc_tick(tick), .system_reset_request(srr), .low_voltage_reset_enable(lv),
    .osc_fail_reset_enable(of), .power_down_disable(pd));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic feed(input logic [7:0] second);
    apb(1'b1, 8'hCC, 8'hA5);
    apb(1'b1, 8'hD0, second);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (srr === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, ext, tick} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rnd = 8'h4A;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'hC4, 8'h00);
    chk(r, 32'hFB);
    apb(1'b0, 8'hC8, 8'h00);
    chk(r, 32'h0);
    apb(1'b0, 8'hE0, 8'h00);
    chk(r, 32'h0);
    chk({lv, of, pd}, 3'b110);
    apb(1'b1, 8'hD4, 8'h00);
    apb(1'b0, 8'hD4, 8'h00);
    chk(r[4], 1'b0);
    rnd = lfsr(rnd);
    w = (rnd & 8'h07) | 8'h04;
    t = 128 * (w + 1);
    // pin is ignored in the programmable part
    ext <= rnd[0];
    apb(1'b1, 8'hC4, 8'h1E);
    chk(pd, 1'b0);
    apb(1'b1, 8'hC8, w);
    feed(8'h5A);
    chk(pd, 1'b1);
    tick <= 1'b1;
    apb(1'b1, 8'hD4, 8'h00);
    repeat (t - 40) @(posedge pclk);
    apb(1'b0, 8'hD4, 8'h00);
    chk(r[4], 1'b0);
    repeat (60) @(posedge pclk);
    apb(1'b0, 8'hD4, 8'h00);
    chk(r[4], 1'b1);
    chk(pulses, 0);
    apb(1'b0, 8'hC8, 8'h00);
    chk(r, {24'h0, w});
    apb(1'b1, 8'hC4, 8'h1C);
    apb(1'b0, 8'hD8, 8'h00);
    s = r;
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'hD8, 8'h00);
    chk(r, s);
    apb(1'b1, 8'hC4, 8'h1E);
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'hD8, 8'h00);
    chk(r !== s, 1'b1);
    feed(8'h5A);
    apb(1'b1, 8'hD4, 8'h00);
    feed(8'h00);
    apb(1'b0, 8'hD4, 8'h00);
    chk(r[4], 1'b1);
    apb(1'b1, 8'hC4, 8'h1B);
    feed(8'h5A);
    feed(8'h5B);
    repeat (2) @(posedge pclk);
    chk(pulses, 1);
    repeat (t + 40) @(posedge pclk);
    chk(pulses, 2);
    tick <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'hD4, 8'h00);
    chk(r[4], 1'b1);
    apb(1'b0, 8'hC4, 8'h00);
    chk(r, 32'hFB);
    report_and_stop();
  end
endmodule
`default_nettype wire
